/* verilog/irq_priority_map.vh */
// Register offsets, implemented-bit masks and reset values of the priority bank
`ifndef IRQ_PRIORITY_MAP_VH
`define IRQ_PRIORITY_MAP_VH
`define PRIO_OFS_U1RX_SPI1_T3 8'h00
`define PRIO_OFS_DMA1_ADC1_U1TX 8'h04
`define PRIO_OFS_CN_I2C1 8'h08
`define PRIO_OFS_CAP78_ADC2_EXT1 8'h0C
`define PRIO_OFS_T4_OC34_DMA2 8'h10
`define PRIO_OFS_U2_EXT2_T5 8'h14
`define PRIO_OFS_CAN1_SPI2 8'h18
`define PRIO_REG_COUNT 7
`define PRIO_FIELD_RESET 3'h4
`define PRIO_SLOT_RESET 4'h4
`define PRIO_LEVEL_OFF 3'h0
`define PRIO_LEVEL_MIN 3'h1
`define PRIO_LEVEL_MAX 3'h7
`define MASK_FULL 16'h7777
`define MASK_DMA1_ADC1_U1TX 16'h0777
`define MASK_CN_I2C1 16'h7077
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

/* verilog/prio_slot_decode.v */
// One 3-bit priority slot: level and enable as seen by the arbiter
`timescale 1ns/1ps
module prio_slot_decode (
    input wire [2:0] field_i,
    output wire [2:0] level_o,
    output wire enabled_o
);
`include "irq_priority_map.vh"
    // Code equals level; 7 highest, 1 lowest enabled
    assign level_o = field_i;
    // Level zero never requests service
    assign enabled_o = (field_i != `PRIO_LEVEL_OFF);
endmodule // prio_slot_decode

/* verilog/irq_priority_regs.v */
// Interrupt priority register bank with AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Field code 111 means priority level 7, the highest.
// - Code 001 is level 1, lowest enabled; codes between map linearly.
// - Code 000 disables the source; it never requests service.
// - Unimplemented bits read zero and ignore writes.
// - Every implemented field resets to 100, level four.
// - Fields sit at bits 14-12, 10-8, 6-4, 2-0; bit 3 of nibbles unused.
// - DMA channel 1 priority at bits 10-8; bits 15-11 unimplemented.
// - Converter 1 done priority at bits 6-4 of that register.
// - Serial 1 transmit priority at bits 2-0 of that register.
// - Serial 2 receive priority at bits 10-8 beside serial 2 transmit.
module irq_priority_regs (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    output wire [2:0] serial1_rx_priority_o,
    output wire [2:0] sync_serial1_event_priority_o,
    output wire [2:0] sync_serial1_error_priority_o,
    output wire [2:0] timer3_priority_o,
    output wire [2:0] dma_ch1_done_priority_o,
    output wire [2:0] conv1_done_priority_o,
    output wire [2:0] serial1_tx_priority_o,
    output wire [2:0] pin_change_priority_o,
    output wire [2:0] twowire1_master_priority_o,
    output wire [2:0] twowire1_slave_priority_o,
    output wire [2:0] capture8_priority_o,
    output wire [2:0] capture7_priority_o,
    output wire [2:0] conv2_done_priority_o,
    output wire [2:0] ext_irq1_priority_o,
    output wire [2:0] timer4_priority_o,
    output wire [2:0] compare4_priority_o,
    output wire [2:0] compare3_priority_o,
    output wire [2:0] dma_ch2_done_priority_o,
    output wire [2:0] serial2_tx_priority_o,
    output wire [2:0] serial2_rx_priority_o,
    output wire [2:0] ext_irq2_priority_o,
    output wire [2:0] timer5_priority_o,
    output wire [2:0] can1_event_priority_o,
    output wire [2:0] can1_rx_ready_priority_o,
    output wire [2:0] sync_serial2_event_priority_o,
    output wire [2:0] sync_serial2_error_priority_o,
    output wire [27:0] source_enabled_o
);
`include "irq_priority_map.vh"

    // Write engine states; one write in flight at a time
    localparam [2:0] WR_IDLE = 3'b001;
    localparam [2:0] WR_RESP = 3'b010;
    localparam [2:0] WR_HOLD = 3'b100;

    // Storage, one flop word per register, indexed by offset / 4
    reg [15:0] prio_r [0:6];
    reg [15:0] prio_nxt [0:6];

    reg [2:0] wr_state_r;
    reg [2:0] wr_state_nxt;
    reg aw_got_r;
    reg w_got_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg [1:0] bresp_r;
    reg bvalid_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;
    integer i;
    integer j;

    // Implemented-bit mask per register index
    function [15:0] reg_mask;
        input [2:0] idx;
        begin
            case (idx)
                3'h1: reg_mask = `MASK_DMA1_ADC1_U1TX;
                3'h2: reg_mask = `MASK_CN_I2C1;
                default: reg_mask = `MASK_FULL;
            endcase
        end
    endfunction

    // Reset image: 100 in every implemented slot
    function [15:0] reg_reset;
        input [2:0] idx;
        begin
            reg_reset = {4{`PRIO_SLOT_RESET}} & reg_mask(idx);
        end
    endfunction

    // Offset decode; valid only for aligned words inside the bank
    function addr_hit;
        input [7:0] addr;
        begin
            addr_hit = (addr[1:0] == 2'h0) && (addr[7:2] < `PRIO_REG_COUNT);
        end
    endfunction

    // Byte-lane merge; strobes above lane 1 address no storage
    function [15:0] lane_merge;
        input [15:0] old_word;
        input [15:0] wr_word;
        input [1:0] strb;
        input [15:0] mask;
        begin
            lane_merge = old_word;
            if (strb[0]) begin
                lane_merge[7:0] = wr_word[7:0] & mask[7:0];
            end
            if (strb[1]) begin
                lane_merge[15:8] = wr_word[15:8] & mask[15:8];
            end
        end
    endfunction

    // A write lands as soon as both address and data have been taken
    wire [7:0] wr_addr = s_axi_awvalid_i && !aw_got_r ? s_axi_awaddr_i : aw_addr_r;
    wire [31:0] wr_data = s_axi_wvalid_i && !w_got_r ? s_axi_wdata_i : w_data_r;
    wire [3:0] wr_strb = s_axi_wvalid_i && !w_got_r ? s_axi_wstrb_i : w_strb_r;
    wire aw_take = (wr_state_r == WR_IDLE) && !aw_got_r && s_axi_awvalid_i;
    wire w_take = (wr_state_r == WR_IDLE) && !w_got_r && s_axi_wvalid_i;
    wire aw_have = aw_got_r || aw_take;
    wire w_have = w_got_r || w_take;
    wire wr_fire = (wr_state_r == WR_IDLE) && aw_have && w_have;
    wire [2:0] wr_idx = wr_addr[4:2];
    wire ar_take = s_axi_arvalid_i && !rvalid_r;
    wire [2:0] rd_idx = s_axi_araddr_i[4:2];
    wire wr_hit = addr_hit(wr_addr);
    wire rd_hit = addr_hit(s_axi_araddr_i);
    wire [15:0] wr_mask = reg_mask(wr_idx);
    wire [15:0] rd_mask = reg_mask(rd_idx);

    // Each channel refused once taken, until the response has been accepted
    assign s_axi_awready_o = (wr_state_r == WR_IDLE) && !aw_got_r;
    assign s_axi_wready_o = (wr_state_r == WR_IDLE) && !w_got_r;
    // Response and read data straight from flops
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    // One read in flight; a new address waits while the answer stands
    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    // Defaults hold every word; only a landing write changes one
    always @* begin
        wr_state_nxt = wr_state_r;
        for (j = 0; j < `PRIO_REG_COUNT; j = j + 1) begin
            prio_nxt[j] = prio_r[j];
        end
        case (wr_state_r)
            WR_IDLE: begin
                if (wr_fire) begin
                    wr_state_nxt = WR_RESP;
                    if (wr_hit) begin
                        // Byte lanes above bit 15 hold nothing; masked bits never store
                        prio_nxt[wr_idx] = lane_merge(prio_r[wr_idx], wr_data[15:0], wr_strb[1:0], wr_mask);
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready_i) begin
                    wr_state_nxt = WR_IDLE;
                end else begin
                    wr_state_nxt = WR_HOLD;
                end
            end
            WR_HOLD: begin
                if (s_axi_bready_i) begin
                    wr_state_nxt = WR_IDLE;
                end
            end
            default: wr_state_nxt = WR_IDLE;
        endcase
    end

    // Write engine; storage and read path live in their own processes below
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_state_r <= WR_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `AXI_RESP_OKAY;
        end else begin
            wr_state_r <= wr_state_nxt;
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_got_r <= 1'b1;
                    aw_addr_r <= s_axi_awaddr_i;
                end
                if (w_take) begin
                    w_got_r <= 1'b1;
                    w_data_r <= s_axi_wdata_i;
                    w_strb_r <= s_axi_wstrb_i;
                end
                if (bvalid_r && s_axi_bready_i) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    // New value visible on the cycle after the write completes
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < `PRIO_REG_COUNT; i = i + 1) begin
                prio_r[i] <= reg_reset(i[2:0]);
            end
        end else begin
            for (i = 0; i < `PRIO_REG_COUNT; i = i + 1) begin
                prio_r[i] <= prio_nxt[i];
            end
        end
    end

    // Read takes the stored word, so a write landing on the same edge shows on the next read
    always @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `AXI_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            if (rd_hit) begin
                // Upper half and unused bits read as zero
                rdata_r <= {16'h0000, prio_r[rd_idx] & rd_mask};
                rresp_r <= `AXI_RESP_OKAY;
            end else begin
                rdata_r <= 32'h00000000;
                rresp_r <= `AXI_RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // Field placement: index 0..6 follows the offset order in the map
    assign serial1_rx_priority_o = prio_r[0][14:12];
    assign sync_serial1_event_priority_o = prio_r[0][10:8];
    assign sync_serial1_error_priority_o = prio_r[0][6:4];
    assign timer3_priority_o = prio_r[0][2:0];
    assign dma_ch1_done_priority_o = prio_r[1][10:8];
    assign conv1_done_priority_o = prio_r[1][6:4];
    assign serial1_tx_priority_o = prio_r[1][2:0];
    assign pin_change_priority_o = prio_r[2][14:12];
    assign twowire1_master_priority_o = prio_r[2][6:4];
    assign twowire1_slave_priority_o = prio_r[2][2:0];
    assign capture8_priority_o = prio_r[3][14:12];
    assign capture7_priority_o = prio_r[3][10:8];
    assign conv2_done_priority_o = prio_r[3][6:4];
    assign ext_irq1_priority_o = prio_r[3][2:0];
    assign timer4_priority_o = prio_r[4][14:12];
    assign compare4_priority_o = prio_r[4][10:8];
    assign compare3_priority_o = prio_r[4][6:4];
    assign dma_ch2_done_priority_o = prio_r[4][2:0];
    assign serial2_tx_priority_o = prio_r[5][14:12];
    assign serial2_rx_priority_o = prio_r[5][10:8];
    assign ext_irq2_priority_o = prio_r[5][6:4];
    assign timer5_priority_o = prio_r[5][2:0];
    assign can1_event_priority_o = prio_r[6][14:12];
    assign can1_rx_ready_priority_o = prio_r[6][10:8];
    assign sync_serial2_event_priority_o = prio_r[6][6:4];
    assign sync_serial2_error_priority_o = prio_r[6][2:0];

    // Enable flags for all 28 slots, index = reg*4 + slot; unused slots stay off
    genvar g;
    generate
        for (g = 0; g < 28; g = g + 1) begin : slot_gen
            wire [2:0] slot_field = prio_r[g / 4][(g % 4) * 4 +: 3];
            prio_slot_decode u_slot (
                .field_i(slot_field),
                .level_o(),
                .enabled_o(source_enabled_o[g])
            );
        end
    endgenerate
endmodule // irq_priority_regs

/* tb/irq_priority_regs_asserts.sv */
// Port-level assertions for the interrupt priority register bank
`timescale 1ns/1ps
module irq_priority_regs_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire s_axi_bvalid_o,
    input wire [2:0] timer4_priority_o,
    input wire [2:0] dma_ch1_done_priority_o,
    input wire [2:0] conv1_done_priority_o,
    input wire [2:0] serial1_tx_priority_o,
    input wire [27:0] source_enabled_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire aw_t = s_axi_awvalid_i && s_axi_awready_o;
    wire w_t = s_axi_wvalid_i && s_axi_wready_o;
    // Only joint address and data acceptance is tied to a fixed update edge
    wire wr1 = aw_t && w_t && s_axi_awaddr_i == 8'h04;
    a_reset_level: assert property ($past(rst_i) |-> timer4_priority_o == 3'h4)
        else $error("level not 4 after reset");
    a_dma1_field: assert property (wr1 && s_axi_wstrb_i[1] |=>
        dma_ch1_done_priority_o == $past(s_axi_wdata_i[10:8])) else $error("dma1 field wrong");
    a_conv1_field: assert property (wr1 && s_axi_wstrb_i[0] |=>
        conv1_done_priority_o == $past(s_axi_wdata_i[6:4])) else $error("conv1 field wrong");
    a_tx1_field: assert property (wr1 && s_axi_wstrb_i[0] |=>
        serial1_tx_priority_o == $past(s_axi_wdata_i[2:0])) else $error("tx1 field wrong");
    a_hold_no_write: assert property (!aw_t && !w_t |=> $stable(timer4_priority_o))
        else $error("field moved without write");
    a_zero_disables: assert property (source_enabled_o[6] == (dma_ch1_done_priority_o != 3'h0))
        else $error("enable does not follow code");
    a_unused_slot: assert property (source_enabled_o[7] == 1'h0 && source_enabled_o[10] == 1'h0)
        else $error("unused slot enabled");
    a_write_answer: assert property (aw_t && w_t |=> s_axi_bvalid_o)
        else $error("no write response");
endmodule // irq_priority_regs_asserts

bind irq_priority_regs irq_priority_regs_asserts u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .timer4_priority_o(timer4_priority_o),
    .dma_ch1_done_priority_o(dma_ch1_done_priority_o),
    .conv1_done_priority_o(conv1_done_priority_o),
    .serial1_tx_priority_o(serial1_tx_priority_o),
    .source_enabled_o(source_enabled_o)
);

/* tb/test_interrupt_priority_registers.sv */
// Self-checking bench for the interrupt priority register bank
`timescale 1ns/1ps
`include "irq_priority_map.vh"
module test_interrupt_priority_registers;
    reg clk_i = 1'h0;
    reg rst_i = 1'h1;
    reg [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    reg [31:0] s_axi_wdata_i = 32'h0;
    reg [3:0] s_axi_wstrb_i = 4'h0;
    reg s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    reg s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0] s_axi_rdata_o;
    wire [27:0] source_enabled_o;
    wire [2:0] f [0:27];
    reg [15:0] exp_r [0:6];
    reg [15:0] d;
    reg [1:0] rsp;
    reg [31:0] rd;
    integer error_cnt = 0, total_checks = 0, cyc = 0, i, k, n, m;
    always #2.5 clk_i = ~clk_i;
    irq_priority_regs dut (.*,
        .serial1_rx_priority_o(f[3]), .sync_serial1_event_priority_o(f[2]), .sync_serial1_error_priority_o(f[1]),
        .timer3_priority_o(f[0]), .dma_ch1_done_priority_o(f[6]), .conv1_done_priority_o(f[5]),
        .serial1_tx_priority_o(f[4]), .pin_change_priority_o(f[11]), .twowire1_master_priority_o(f[9]),
        .twowire1_slave_priority_o(f[8]), .capture8_priority_o(f[15]), .capture7_priority_o(f[14]),
        .conv2_done_priority_o(f[13]), .ext_irq1_priority_o(f[12]), .timer4_priority_o(f[19]),
        .compare4_priority_o(f[18]), .compare3_priority_o(f[17]), .dma_ch2_done_priority_o(f[16]),
        .serial2_tx_priority_o(f[23]), .serial2_rx_priority_o(f[22]), .ext_irq2_priority_o(f[21]),
        .timer5_priority_o(f[20]), .can1_event_priority_o(f[27]), .can1_rx_ready_priority_o(f[26]),
        .sync_serial2_event_priority_o(f[25]), .sync_serial2_error_priority_o(f[24]));
    function [15:0] msk(input integer x);
        msk = x == 1 ? `MASK_DMA1_ADC1_U1TX : x == 2 ? `MASK_CN_I2C1 : `MASK_FULL;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One bus access; handshakes are judged at the falling edge so the rising edge sees settled values
    task acc(input w, input [7:0] a, input [15:0] dd, input [3:0] s);
        reg ta, tw, tr, tb, ok;
        reg [15:0] lm;
        begin
            tb = 1'h0;
            @(posedge clk_i);
            s_axi_awaddr_i <= a;
            s_axi_araddr_i <= a;
            s_axi_wdata_i <= ($urandom & 32'hFFFF0000) | dd;
            s_axi_wstrb_i <= s;
            s_axi_awvalid_i <= w;
            s_axi_wvalid_i <= w;
            s_axi_bready_i <= w;
            s_axi_arvalid_i <= !w;
            s_axi_rready_i <= !w;
            while (!tb) begin
                @(negedge clk_i);
                ta = s_axi_awvalid_i && s_axi_awready_o;
                tw = s_axi_wvalid_i && s_axi_wready_o;
                tr = s_axi_arvalid_i && s_axi_arready_o;
                tb = w ? s_axi_bvalid_o : s_axi_rvalid_o;
                rsp = w ? s_axi_bresp_o : s_axi_rresp_o;
                rd = s_axi_rdata_o;
                @(posedge clk_i);
                if (ta) s_axi_awvalid_i <= 1'h0;
                if (tw) s_axi_wvalid_i <= 1'h0;
                if (tr) s_axi_arvalid_i <= 1'h0;
            end
            s_axi_bready_i <= 1'h0;
            s_axi_rready_i <= 1'h0;
            lm = {{8{s[1]}}, {8{s[0]}}};
            ok = a < 8'h1C && a[1:0] == 2'h0;
            chk(rsp, ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR);
            if (w && ok)
                exp_r[a >> 2] = ((exp_r[a >> 2] & ~lm) | (dd & lm)) & msk(a >> 2);
        end
    endtask
    task chk_all;
        begin
            for (i = 0; i < 7; i = i + 1) begin
                acc(1'h0, 8'(i * 4), 16'h0, 4'h0);
                chk(rd, {16'h0, exp_r[i]});
                for (k = 0; k < 4; k = k + 1) begin
                    if ((msk(i) >> (k * 4) & 16'h7) != 16'h0)
                        chk(f[i * 4 + k], exp_r[i] >> (k * 4) & 16'h7);
                    chk(source_enabled_o[i * 4 + k], exp_r[i][k * 4 +: 3] != 3'h0);
                end
            end
            acc(1'h0, 8'h1C, 16'h0, 4'h0);
            chk(rd, 32'h0);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t timeout", $time);
            end_sim;
        end
    end
    initial begin
        d = 16'($urandom(32'h18AA3FF4));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        for (n = 0; n < 7; n = n + 1)
            exp_r[n] = 16'h4444 & msk(n);
        chk_all;
        // Every code in every slot, with the unused nibble tops set
        for (n = 0; n < 8; n = n + 1) begin
            for (m = 0; m < 7; m = m + 1)
                acc(1'h1, 8'(m * 4), {4{1'h1, 3'(n)}}, 4'h3);
            chk_all;
        end
        for (n = 0; n < 60; n = n + 1) begin
            d = 16'($urandom);
            acc(1'h1, 8'($urandom % 8 * 4 + ($urandom % 6 == 0)), d, 4'($urandom));
            chk_all;
        end
        @(posedge clk_i);
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        for (n = 0; n < 7; n = n + 1)
            exp_r[n] = 16'h4444 & msk(n);
        chk_all;
        end_sim;
    end
endmodule // test_interrupt_priority_registers
